// ### hw/digipot_cfg.svh
`ifndef DIGIPOT_CFG_SVH
`define DIGIPOT_CFG_SVH

// ==========================================
// Instruction byte layout and opcodes
`define OPC_MSB        7
`define OPC_LSB        5
`define ADDR_MSB       4
`define OPC_NOP        3'h0
`define OPC_CTRL_RD    3'h1
`define OPC_CTRL_WR    3'h3
`define OPC_ADDR_RD    3'h4
`define OPC_ADDR_WR    3'h6
`define ADDR_WIPER     5'h00
`define ADDR_ACR       5'h10

// ==========================================
// Register reset values and field masks
`define WIPER_RESET    8'h40
`define WIPER_MASK     8'h7F
`define ACR_RESET      8'h40
`define ACR_MASK       8'h42
`define ACR_OD_BIT     1
`define ACR_SHDN_BIT   6

// ==========================================
// Link timing, system clock 250 MHz
`define CLK_MHZ        250
`define T_CYC_NS       200
`define T_LEAD_NS      250
`define T_LAG_NS       250
`define T_CS_US        2
`define HALF_CYC       ((`T_CYC_NS * `CLK_MHZ + 1999) / 2000)
`define LEAD_CYC       ((`T_LEAD_NS * `CLK_MHZ + 999) / 1000)
`define LAG_CYC        ((`T_LAG_NS * `CLK_MHZ + 999) / 1000)
`define CSD_CYC        (`T_CS_US * `CLK_MHZ)

`endif

// ### hw/digipot_pkg.sv
package digipot_pkg;

    // ==========================================
    // Host sequencer states
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_HIGH = 3'b010,
        H_LOW  = 3'b011,
        H_LAG  = 3'b100,
        H_GAP  = 3'b101
    } host_state_t;

    // ==========================================
    // Whole state of the device end
    typedef struct packed {
        logic [2:0] sck_s;    // Clock sync plus edge stage
        logic [2:0] cs_s;     // Select sync plus edge stage
        logic [1:0] sdi_s;    // Data-in sync
        logic       armed;    // First select fall seen
        logic [2:0] bit_cnt;  // Bits of current byte
        logic [1:0] byte_cnt; // Byte index, saturates at 3
        logic [7:0] shift;    // Receive shifter
        logic [7:0] instr;    // Captured instruction
        logic [7:0] data;     // Last data byte
        logic       got_data; // A data byte completed
        logic [7:0] wiper;    // Wiper position
        logic [7:0] access_control_reg;      // Access control
        logic       sdo;      // Output bit
    } dev_state_t;

    // ==========================================
    // Whole state of the host end
    typedef struct packed {
        host_state_t st;      // Sequencer state
        logic [8:0]  cnt;     // Phase timer
        logic [4:0]  bit_idx; // Bits sent
        logic        rd;      // Read frame
        logic [31:0] tx;      // Transmit shifter
        logic [31:0] rx;      // Receive shifter
        logic        sck;     // Link clock
        logic        cs_n;    // Select, low active
        logic        mosi;    // Serial data out
        logic [1:0]  miso_s;  // Data-in sync
        logic        done;    // Completion pulse
        logic [7:0]  rdata;   // Read value
        logic [7:0]  echo;    // Echoed instruction
    } host_reg_t;

endpackage : digipot_pkg

// ### hw/spi_link_if.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Serial link between host and potentiometer
interface spi_link_if;
    logic sck;    // Link clock from host
    logic cs_n;   // Select, low active
    logic sdi;    // Host to device data
    logic sdo_o;  // Device output value
    logic sdo_oe; // Device output enable
    logic sdo;    // Resolved line level

    // Undriven line floats to the external pull-up
    assign sdo = sdo_oe ? sdo_o : 1'b1;

    modport device (input sck, input cs_n, input sdi, output sdo_o, output sdo_oe);
    modport host   (output sck, output cs_n, output sdi, input sdo);
endinterface : spi_link_if

`default_nettype wire

// ### hw/digipot_spi_slave.sv
// Notes on behaviour
// - Value 127 high terminal, 0 low terminal
// - Tap follows wiper register directly
// - Sample input on rising clock, select low
// - Host sends opcode, address, data serially
// - Output changes on falling clock edge
// - Control bit 1 selects open-drain output
// - Push-pull output after power-up
// - Output released while select high
// - Select low active, high standby
// - Ignore bus until first select fall
// - Opcode three bits, address five bits
// - Writes take effect at select rise
// - Read four bytes, echo then value
// - Bytes MSB first, clock mode 0
`include "digipot_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module digipot_spi_slave
    import digipot_pkg::*;
(
    input  wire logic  mclk_in,        // System clock
    input  wire logic  reset_n_in,     // Async reset, low active
    spi_link_if.device link,           // Serial link
    output logic [6:0] wiper_tap_out,  // Selected tap index
    output logic       shutdown_n_out, // Shutdown control, low active
    output logic       active_out      // Device selected
);

    // ==========================================
    // State and edge terms
    dev_state_t q;        // Registered state
    dev_state_t d;        // Next state
    logic       sck_rise; // Link clock rose
    logic       sck_fall; // Link clock fell
    logic       cs_fall;  // Select fell
    logic       cs_rise;  // Select rose
    logic       sel;      // Armed and selected
    logic       od;       // Open-drain output mode
    logic [7:0] tx_now;   // Byte owed in the current slot

    assign sck_rise = q.sck_s[1] & ~q.sck_s[2];
    assign sck_fall = ~q.sck_s[1] & q.sck_s[2];
    assign cs_fall  = ~q.cs_s[1] & q.cs_s[2];
    assign cs_rise  = q.cs_s[1] & ~q.cs_s[2];
    assign sel      = q.armed & ~q.cs_s[1];
    assign od       = q.access_control_reg[`ACR_OD_BIT];
    // Named net so a bit can be picked; a call result cannot be indexed
    assign tx_now   = tx_byte(q);

    // ==========================================
    // Decoders
    // Write target: 0 none, 1 wiper, 2 control
    function automatic logic [1:0] wr_target(input logic [7:0] ins);
        logic [2:0] op;
        logic [4:0] ad;
        op = ins[`OPC_MSB:`OPC_LSB];
        ad = ins[`ADDR_MSB:0];
        wr_target = 2'h0;
        if (op == `OPC_CTRL_WR) begin
            wr_target = 2'h2;
        end else if (op == `OPC_ADDR_WR) begin
            if (ad == `ADDR_WIPER) begin
                wr_target = 2'h1;
            end else if (ad == `ADDR_ACR) begin
                wr_target = 2'h2;
            end
        end
    endfunction : wr_target

    // Read target, same coding; unknown codes are no-ops
    function automatic logic [1:0] rd_target(input logic [7:0] ins);
        logic [2:0] op;
        logic [4:0] ad;
        op = ins[`OPC_MSB:`OPC_LSB];
        ad = ins[`ADDR_MSB:0];
        rd_target = 2'h0;
        if (op == `OPC_CTRL_RD) begin
            rd_target = 2'h2;
        end else if (op == `OPC_ADDR_RD) begin
            if (ad == `ADDR_WIPER) begin
                rd_target = 2'h1;
            end else if (ad == `ADDR_ACR) begin
                rd_target = 2'h2;
            end
        end
    endfunction : rd_target

    // Byte placed on the output for the current byte slot
    function automatic logic [7:0] tx_byte(input dev_state_t s);
        logic [1:0] t;
        t = rd_target(s.instr);
        tx_byte = 8'h00;
        if (s.instr[`OPC_MSB:`OPC_LSB] == `OPC_CTRL_RD ||
            s.instr[`OPC_MSB:`OPC_LSB] == `OPC_ADDR_RD) begin
            if (s.byte_cnt == 2'h2) begin
                tx_byte = s.instr;
            end else if (s.byte_cnt == 2'h3) begin
                if (t == 2'h1) begin
                    tx_byte = s.wiper;
                end else if (t == 2'h2) begin
                    tx_byte = s.access_control_reg;
                end
            end
        end
    endfunction : tx_byte

    // ==========================================
    // Next-state logic
    always_comb begin
        d = q;
        // Pins pass two flops before any use
        d.sck_s = {q.sck_s[1:0], link.sck};
        d.cs_s  = {q.cs_s[1:0], link.cs_n};
        d.sdi_s = {q.sdi_s[0], link.sdi};
        if (cs_fall) begin
            // New frame: arm and restart counters
            d.armed    = 1'b1;
            d.bit_cnt  = 3'h0;
            d.byte_cnt = 2'h0;
            d.got_data = 1'b0;
            d.sdo      = 1'b0;
        end else if (cs_rise) begin
            // Deferred commit keeps partial frames harmless
            if (q.armed && q.got_data) begin
                case (wr_target(q.instr))
                    2'h1: d.wiper = q.data & `WIPER_MASK;
                    2'h2: d.access_control_reg = q.data & `ACR_MASK;
                    default: d.wiper = q.wiper;           // No write
                endcase
            end
        end else if (sel) begin
            if (sck_rise) begin
                // Shift MSB first on the rising edge
                d.shift   = {q.shift[6:0], q.sdi_s[1]};
                d.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == 3'h7) begin
                    if (q.byte_cnt == 2'h0) begin
                        d.instr = {q.shift[6:0], q.sdi_s[1]};
                    end else begin
                        // Last data byte of a long write wins
                        d.data     = {q.shift[6:0], q.sdi_s[1]};
                        d.got_data = 1'b1;
                    end
                    if (q.byte_cnt != 2'h3) begin
                        d.byte_cnt = q.byte_cnt + 2'h1;
                    end
                end
            end
            if (sck_fall) begin
                // Next bit launched on the falling edge
                d.sdo = tx_now[~q.bit_cnt];
            end
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q.sck_s    <= 3'h0;
            q.cs_s     <= 3'h0; // Held-low select is no fall
            q.sdi_s    <= 2'h0;
            q.armed    <= 1'b0;
            q.bit_cnt  <= 3'h0;
            q.byte_cnt <= 2'h0;
            q.shift    <= 8'h00;
            q.instr    <= 8'h00;
            q.data     <= 8'h00;
            q.got_data <= 1'b0;
            q.wiper    <= `WIPER_RESET;
            q.access_control_reg      <= `ACR_RESET;
            q.sdo      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Pin drive and analog-side outputs
    // Open drain only ever pulls low; push-pull drives both
    assign link.sdo_o     = od ? 1'b0 : q.sdo;
    assign link.sdo_oe    = sel & (od ? ~q.sdo : 1'b1);
    assign wiper_tap_out  = q.wiper[6:0];
    assign shutdown_n_out = q.access_control_reg[`ACR_SHDN_BIT];
    assign active_out     = sel;

endmodule : digipot_spi_slave

`default_nettype wire

// ### hw/digipot_spi_host.sv
`include "digipot_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module digipot_spi_host
    import digipot_pkg::*;
(
    input  wire logic  mclk_in,    // System clock
    input  wire logic  reset_n_in, // Async reset, low active
    spi_link_if.host   link,       // Serial link
    input  wire logic  start_in,   // Start a frame when idle
    input  wire logic  read_in,    // 1 read, 0 write
    input  wire logic [7:0] instr_in, // Instruction byte
    input  wire logic [7:0] wdata_in, // Write data byte
    output logic       busy_out,   // Frame in progress
    output logic       done_out,   // Frame finished pulse
    output logic [7:0] rdata_out,  // Read value
    output logic [7:0] echo_out    // Echoed instruction
);

    // ==========================================
    // Timing constants
    localparam logic [8:0] HALF = 9'(`HALF_CYC);
    localparam logic [8:0] LEAD = 9'(`LEAD_CYC);
    localparam logic [8:0] LAG  = 9'(`LAG_CYC);
    localparam logic [8:0] CSD  = 9'(`CSD_CYC);

    host_reg_t q;    // Registered state
    host_reg_t d;    // Next state
    logic      tick; // Current phase ends
    logic [4:0] last; // Index of final bit

    assign tick = (q.cnt == 9'h001);
    assign last = q.rd ? 5'h1F : 5'h0F;

    // ==========================================
    // Sequencer; the divider is the phase timer
    always_comb begin
        d = q;
        d.miso_s = {q.miso_s[0], link.sdo};
        d.done   = 1'b0;
        if (q.cnt != 9'h000) begin
            d.cnt = q.cnt - 9'h001;
        end
        case (q.st)
            H_IDLE: begin
                if (start_in) begin
                    // Read is instr, dummy, no-op, dummy
                    d.rd      = read_in;
                    d.tx      = read_in ? {instr_in, 24'h000000}
                                        : {instr_in, wdata_in, 16'h0000};
                    d.cs_n    = 1'b0;
                    d.mosi    = instr_in[7];
                    d.bit_idx = 5'h00;
                    d.cnt     = LEAD;
                    d.st      = H_LEAD;
                end
            end
            H_LEAD, H_LOW: begin
                if (tick) begin
                    // Rising edge: bit is settled, take reply bit
                    d.sck = 1'b1;
                    d.rx  = {q.rx[30:0], q.miso_s[1]};
                    d.cnt = HALF;
                    d.st  = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tick) begin
                    d.sck = 1'b0;
                    d.tx  = {q.tx[30:0], 1'b0};
                    if (q.bit_idx == last) begin
                        d.cnt = LAG;
                        d.st  = H_LAG;
                    end else begin
                        d.bit_idx = q.bit_idx + 5'h01;
                        d.mosi    = q.tx[30];
                        d.cnt     = HALF;
                        d.st      = H_LOW;
                    end
                end
            end
            H_LAG: begin
                if (tick) begin
                    // Select rise commits the device write
                    d.cs_n  = 1'b1;
                    d.done  = 1'b1;
                    d.echo  = q.rx[15:8];
                    d.rdata = q.rx[7:0];
                    d.cnt   = CSD;
                    d.st    = H_GAP;
                end
            end
            H_GAP: begin
                // Deselect time before next frame
                if (tick) begin
                    d.st = H_IDLE;
                end
            end
            default: d.st = H_IDLE;
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q.st      <= H_IDLE;
            q.cnt     <= 9'h000;
            q.bit_idx <= 5'h00;
            q.rd      <= 1'b0;
            q.tx      <= 32'h00000000;
            q.rx      <= 32'h00000000;
            q.sck     <= 1'b0;
            q.cs_n    <= 1'b1;
            q.mosi    <= 1'b0;
            q.miso_s  <= 2'h3;
            q.done    <= 1'b0;
            q.rdata   <= 8'h00;
            q.echo    <= 8'h00;
        end else begin
            q <= d;
        end
    end

    assign link.sck  = q.sck;
    assign link.cs_n = q.cs_n;
    assign link.sdi  = q.mosi;
    assign busy_out  = (q.st != H_IDLE);
    assign done_out  = q.done;
    assign rdata_out = q.rdata;
    assign echo_out  = q.echo;

endmodule : digipot_spi_host

`default_nettype wire

// ### verification/digipot_spi_chk.sv
`timescale 1ns/100ps
`default_nettype none

// ======
// Link watcher between host and device ends
module digipot_spi_chk (
    input wire logic mclk_in,    // System clock
    input wire logic reset_n_in, // Async reset, low active
    input wire logic sck,        // Link clock
    input wire logic cs_n,       // Select, low active
    input wire logic sdi,        // Host to device data
    input wire logic sdo_o,      // Device output value
    input wire logic sdo_oe,     // Device output enable
    input wire logic sdo         // Resolved line level
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    logic       sck_q;  // Clock one sample back
    logic [5:0] edge_q; // Rising clock edges in frame
    logic [5:0] high_q; // Samples with clock high

    // ======
    // Helper counters, cleared between frames
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_q  <= 1'b0;
            edge_q <= 6'h00;
            high_q <= 6'h00;
        end else begin
            sck_q  <= sck;
            edge_q <= cs_n ? 6'h00 : edge_q + {5'h00, sck & ~sck_q};
            high_q <= sck ? high_q + 6'h01 : 6'h00;
        end
    end

    // ======
    // Line rules
    AST_OE_DESEL: assert property (cs_n [*4] |-> !sdo_oe && sdo)
        else $error("output driven while deselected");
    AST_SDO_FALL: assert property (($changed(sdo) && !cs_n) |-> !sck)
        else $error("output moved while clock high");
    AST_SDI_HOLD: assert property (($rose(sck) && !cs_n) |-> $stable(sdi) [*8])
        else $error("input data moved near rising clock");
    AST_LEAD: assert property ($fell(cs_n) |-> ##1 ($stable(sdi) && !sck) [*8])
        else $error("first bit not set up ahead of clock");
    AST_CS_EDGE: assert property ($changed(cs_n) |-> !sck && !$past(sck))
        else $error("select moved with clock high");
    AST_SCK_IDLE: assert property (cs_n |-> !sck)
        else $error("clock not idle low between frames");
    AST_BITS: assert property ($rose(cs_n) |-> edge_q == 6'h10 || edge_q == 6'h20)
        else $error("frame not two or four whole bytes");
    AST_HALF: assert property ($fell(sck) |-> high_q == 6'h19)
        else $error("clock high phase length wrong");

    // Main scenarios reached
    cover property ($rose(cs_n) && edge_q == 6'h10);
    cover property ($rose(cs_n) && edge_q == 6'h20);
    cover property (!cs_n && !sdo_oe && sdo);
endmodule : digipot_spi_chk

`default_nettype wire

// ### verification/digipot_spi_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none

module digipot_spi_slave_tb;
    import digipot_pkg::*;

    logic       mclk, rst_n, start, rd, shdn_n, act, busy, done; // Bench lines
    logic [7:0] instr, wdata, rdata, echo;                      // Command data
    logic [6:0] tap;                                            // Tap index
    int         err_count, checks_done, cyc, wiper, access_control_reg;        // Counters and model
    spi_link_if lnk();

    // ======
    // Both ends face each other on one link
    digipot_spi_slave digipot_spi_slave_i (.mclk_in(mclk), .reset_n_in(rst_n), .link(lnk),
        .wiper_tap_out(tap), .shutdown_n_out(shdn_n), .active_out(act));
    digipot_spi_host digipot_spi_host_i (.mclk_in(mclk), .reset_n_in(rst_n), .link(lnk),
        .start_in(start), .read_in(rd), .instr_in(instr), .wdata_in(wdata),
        .busy_out(busy), .done_out(done), .rdata_out(rdata), .echo_out(echo));
    digipot_spi_chk chk_i (.mclk_in(mclk), .reset_n_in(rst_n), .sck(lnk.sck), .cs_n(lnk.cs_n),
        .sdi(lnk.sdi), .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe), .sdo(lnk.sdo));

    // ======
    // Clock and hang guard, sized for about 54k cycles of traffic
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            $display("BAD %0t run hung", $time);
            end_of_test();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // Model read value; bad address or opcode reads zero
    function automatic logic [7:0] exp_rd(input logic [7:0] i);
        if (i[7:5] == 3'h1 || (i[7:5] == 3'h4 && i[4:0] == 5'h10)) return access_control_reg[7:0];
        if (i[7:5] == 3'h4 && i[4:0] == 5'h00) return wiper[7:0];
        return 8'h00;
    endfunction : exp_rd

    // ======
    // One host frame; model commits only after select rises
    task automatic xfer(input logic r, input logic [7:0] i, input logic [7:0] d);
        int n;
        n = 0;
        start = 1'b1;
        rd    = r;
        instr = i;
        wdata = d;
        @(posedge mclk);
        #1 start = 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            if (lnk.cs_n === 1'b0) cmp({1'b0, tap}, {1'b0, wiper[6:0]}, "tap moved in frame");
            if (act === 1'b1 && access_control_reg[1]) cmp({7'h00, lnk.sdo_oe & lnk.sdo_o}, 8'h00, "od high");
            if (act === 1'b1 && !access_control_reg[1]) cmp({7'h00, lnk.sdo_oe}, 8'h01, "pp off");
            @(posedge mclk);
            #1 n++;
        end
        if (n >= 3000) cmp(8'h00, 8'h01, "no done");
        if (r) begin
            cmp(echo, i, "echo");
            cmp(rdata, exp_rd(i), "read");
        end else begin
            if (i[7:5] == 3'h3 || (i[7:5] == 3'h6 && i[4:0] == 5'h10)) access_control_reg = d & 8'h42;
            if (i[7:5] == 3'h6 && i[4:0] == 5'h00) wiper = d & 8'h7F;
        end
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            #1 n++;
        end
        cmp({1'b0, tap}, {1'b0, wiper[6:0]}, "tap");
        cmp({7'h00, shdn_n}, {7'h00, access_control_reg[6]}, "shutdown");
        cmp({7'h00, lnk.sdo_oe}, 8'h00, "oe idle");
        cmp({7'h00, act}, 8'h00, "active idle");
    endtask : xfer

    // ======
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] lim [3];
        lim   = '{8'h00, 8'h7F, 8'hFF};
        rst_n = 1'b0;
        start = 1'b0;
        rd    = 1'b0;
        instr = 8'h00;
        wdata = 8'h00;
        wiper = 8'h40;
        access_control_reg   = 8'h40;
        void'($urandom(60));
        repeat (3) @(posedge mclk);
        #1 rst_n = 1'b1;
        cmp({1'b0, tap}, 8'h40, "reset tap");
        cmp({7'h00, shdn_n}, 8'h01, "reset shutdown");
        cmp({7'h00, lnk.sdo_oe}, 8'h00, "reset oe");
        xfer(1'b1, 8'h20, 8'h00);
        xfer(1'b1, 8'h90, 8'h00);
        for (int op = 0; op < 8; op++) begin
            d = 8'($urandom);
            xfer(1'b0, {op[2:0], op[0], 4'h0}, d);
            xfer(1'b1, {3'h4, op[0], 4'h0}, 8'h00);
        end
        foreach (lim[k]) begin
            xfer(1'b0, 8'hC0, lim[k]);
            xfer(1'b1, 8'h80, 8'h00);
        end
        xfer(1'b0, 8'h75, 8'hFF);
        xfer(1'b1, 8'h80, 8'h00);
        xfer(1'b0, 8'hD0, 8'h00);
        xfer(1'b1, {3'h4, 5'($urandom)}, 8'h00);
        xfer(1'b1, 8'h95, 8'h00);
        end_of_test();
    end
endmodule : digipot_spi_slave_tb

`default_nettype wire
